// file: verilog/kbc_host_pkg.sv
// constants, field positions and command codes of the host port
package kbc_host_pkg;
	localparam logic [7:0] data_port_addr = 8'h60;
	localparam logic [7:0] cmd_port_addr = 8'h64;
	// status bit positions
	localparam int st_obf = 0;
	localparam int st_ibf = 1;
	localparam int st_sys = 2;
	localparam int st_cd = 3;
	localparam int st_inh = 4;
	localparam int st_aux = 5;
	localparam int st_tmo = 6;
	localparam int st_par = 7;
	// command byte bit positions
	localparam int cb_kint = 0;
	localparam int cb_aint = 1;
	localparam int cb_sys = 2;
	localparam int cb_kdis = 4;
	localparam int cb_adis = 5;
	localparam int cb_xlat = 6;
	localparam logic [7:0] cb_reset = 8'h00;
	localparam logic [7:0] cb_mask = 8'h77;
	localparam int gate_bit = 1;
	// commands
	localparam logic [7:0] c_rd_cb = 8'h20;
	localparam logic [7:0] c_wr_cb = 8'h60;
	localparam logic [7:0] c_pw_test = 8'ha4;
	localparam logic [7:0] c_pw_load = 8'ha5;
	localparam logic [7:0] c_pw_en = 8'ha6;
	localparam logic [7:0] c_aux_dis = 8'ha7;
	localparam logic [7:0] c_aux_en = 8'ha8;
	localparam logic [7:0] c_aux_test = 8'ha9;
	localparam logic [7:0] c_self_test = 8'haa;
	localparam logic [7:0] c_kbd_test = 8'hab;
	localparam logic [7:0] c_kbd_dis = 8'had;
	localparam logic [7:0] c_kbd_en = 8'hae;
	localparam logic [7:0] c_rd_in = 8'hc0;
	localparam logic [7:0] c_poll_lo = 8'hc1;
	localparam logic [7:0] c_poll_hi = 8'hc2;
	localparam logic [7:0] c_rd_out = 8'hd0;
	localparam logic [7:0] c_gate = 8'hd1;
	localparam logic [7:0] c_echo_kbd = 8'hd2;
	localparam logic [7:0] c_echo_aux = 8'hd3;
	localparam logic [7:0] c_wr_aux = 8'hd4;
	localparam logic [7:0] c_rd_test = 8'he0;
	localparam logic [3:0] c_reset_grp = 4'hf;
	// answers
	localparam logic [7:0] r_pw_loaded = 8'hfa;
	localparam logic [7:0] r_pw_none = 8'hf1;
	localparam logic [7:0] r_self_ok = 8'h55;
	// timing
	localparam int clk_mhz = 50;
	localparam int reset_pulse_us = 6;
	localparam int reset_pulse_cyc = reset_pulse_us * clk_mhz;
	localparam int pw_depth = 8;
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_wr_cb = 3'b001,
		st_pw = 3'b010,
		st_gate = 3'b011,
		st_echo_k = 3'b100,
		st_echo_a = 3'b101,
		st_aux_wr = 3'b110
	} wait_t;
endpackage : kbc_host_pkg

// file: verilog/kbc_out_if.sv
// output-buffer load path between interpreter and output buffer
interface kbc_out_if;
	logic load;
	logic [7:0] data;
	logic aux;
	modport src (output load, output data, output aux);
	modport dst (input load, input data, input aux);
endinterface : kbc_out_if

// file: verilog/kbc_pw_mem.sv
// small password store with registered read data
module kbc_pw_mem #(
	parameter int depth = 8
) (
	input wire logic core_clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [$clog2(depth)-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [$clog2(depth)-1:0] raddr,
	output logic [7:0] rdata
);
	if (depth < 2) begin : g_depth_bad
		$error("depth too small");
	end
	logic [7:0] mem [depth];
	always_ff @(posedge core_clk) begin
		if (ce) begin
			if (we) mem[waddr] <= wdata;
			rdata <= mem[raddr];
		end
	end
endmodule : kbc_pw_mem

// file: verilog/kbc_out_buf.sv
// host-readable output buffer with full and aux-source flags
module kbc_out_buf (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	kbc_out_if.dst ld,
	input wire logic rd_take,
	output logic [7:0] data_r,
	output logic full_r,
	output logic aux_r
);
	logic [7:0] data_nxt;
	logic full_nxt;
	logic aux_nxt;
	always_comb begin
		data_nxt = data_r;
		full_nxt = full_r;
		aux_nxt = aux_r;
		if (rd_take) begin
			full_nxt = 1'b0;
			aux_nxt = 1'b0;
		end
		// a new load wins over a same-cycle host read
		if (ld.load) begin
			data_nxt = ld.data;
			full_nxt = 1'b1;
			aux_nxt = ld.aux;
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			data_r <= 8'h00;
			full_r <= 1'b0;
			aux_r <= 1'b0;
		end else if (ce) begin
			data_r <= data_nxt;
			full_r <= full_nxt;
			aux_r <= aux_nxt;
		end
	end
endmodule : kbc_out_buf

// file: verilog/kbc_host_port.sv
// host command interpreter and status of the keyboard controller
// What this block does
// RULE_01: eight-bit write-only input buffer loaded at data port or command port.
// RULE_02: data-port write marks data, command-port write marks command; status bit 3.
// RULE_03: data bytes go to keyboard unless a parameter is awaited; host waits on empty.
// RULE_04: read-only status at command port, readable any time without side effect.
// RULE_05: status bit 0 output buffer full, bit 1 input buffer full.
// RULE_06: status bit 2 mirrors command byte system flag, zero after reset.
// RULE_07: status bit 4 shows keyboard inhibit switch.
// RULE_08: status bit 5 set when output byte came from auxiliary device.
// RULE_09: status bit 6 reports serial time-out error.
// RULE_10: status bit 7 reports even-parity receive error.
// RULE_11: commands read and write the command byte with its defined fields.
// RULE_12: password test returns fa when loaded, f1 when not.
// RULE_13: load-password stores data bytes until a zero byte arrives. The code stores at most pw_len-1 bytes and drops further ones.
// RULE_14: enable-password starts matching keystrokes against the stored password.
// RULE_15: interface tests return 00 to 04 diagnostic codes.
// RULE_16: self-test returns 55 on success.
// RULE_17: send input port, poll its nibbles into status, send output port. The code polls controller_input_lines nibbles, not host_input_port.
// RULE_18: gate command's next data byte bit 1 drives the address-line-20 gate.
// RULE_19: echo commands return next data byte as keyboard or auxiliary data.
// RULE_20: auxiliary-write sends next data byte to auxiliary device.
// RULE_21: test-input command returns the test inputs.
// RULE_22: even reset-group command pulses cpu reset low for 6 us.
// RULE_23: output buffer read at data port while its full flag is one.
// RULE_24: separate commands disable and enable aux and keyboard interfaces.
module kbc_host_port
	import kbc_host_pkg::*;
#(
	parameter int pw_len = pw_depth
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic [7:0] host_input_port,
	input wire logic [7:0] controller_input_lines,
	input wire logic [1:0] test_inputs,
	input wire logic inhibit_n,
	input wire logic timeout_err,
	input wire logic parity_err,
	input wire logic [7:0] aux_diag,
	input wire logic [7:0] kbd_diag,
	input wire logic self_test_ok,
	input wire logic rx_valid,
	input wire logic rx_aux,
	input wire logic [7:0] rx_data,
	output logic kbd_tx_valid,
	output logic aux_tx_valid,
	output logic [7:0] tx_data,
	output logic pw_active,
	output logic pw_match,
	output logic [7:0] cmd_byte,
	output logic address_line_20_gate,
	output logic cpu_reset_line
);
	localparam int aw = $clog2(pw_len);
	if (pw_len < 2 || pw_len > 256) begin : g_pw_len_bad
		$error("pw_len out of range");
	end

	// ==========================================================
	// host access decode
	logic wr_data, wr_cmd, rd_data;
	assign wr_data = io_wr && io_addr == data_port_addr; // RULE_01
	assign wr_cmd = io_wr && io_addr == cmd_port_addr; // RULE_01
	assign rd_data = io_rd && io_addr == data_port_addr; // RULE_23

	// ==========================================================
	// input buffer
	logic [7:0] ib_r, ib_nxt;
	logic ibf_r, ibf_nxt, cd_r, cd_nxt;
	logic consume;
	always_comb begin
		ib_nxt = ib_r;
		ibf_nxt = ibf_r;
		cd_nxt = cd_r;
		if (consume) ibf_nxt = 1'b0;
		// writes while full are dropped: the host must wait for empty
		if ((wr_data || wr_cmd) && !ibf_r) begin // RULE_03
			ib_nxt = io_wdata; // RULE_01
			ibf_nxt = 1'b1;
			cd_nxt = wr_cmd; // RULE_02
		end
	end

	// ==========================================================
	// output buffer
	kbc_out_if ob_ld();
	logic [7:0] ob_data;
	logic obf, ob_aux;
	kbc_out_buf u_ob (
		.core_clk(core_clk),
		.rstn(rstn),
		.ce(ce),
		.ld(ob_ld),
		.rd_take(rd_data && obf), // RULE_23
		.data_r(ob_data),
		.full_r(obf),
		.aux_r(ob_aux)
	);

	// ==========================================================
	// password store
	logic [aw-1:0] pw_wa_r, pw_wa_nxt, pw_ra_r, pw_ra_nxt;
	logic pw_ld_r, pw_ld_nxt, pw_act_r, pw_act_nxt, pw_hit_r, pw_hit_nxt;
	logic pw_we;
	logic [7:0] pw_rd;
	kbc_pw_mem #(.depth(pw_len)) u_pw (
		.core_clk(core_clk),
		.ce(ce),
		.we(pw_we),
		.waddr(pw_wa_r),
		.wdata(ib_r),
		.raddr(pw_ra_r),
		.rdata(pw_rd)
	);

	// ==========================================================
	// command interpreter
	wait_t wt_r, wt_nxt;
	logic [7:0] cb_r, cb_nxt;
	logic gate_r, gate_nxt;
	logic [1:0] poll_r, poll_nxt;
	logic [8:0] rst_cnt_r, rst_cnt_nxt;
	logic kbd_tx_nxt, aux_tx_nxt;
	logic [7:0] tx_nxt;
	logic [7:0] ob_d;
	logic ob_l, ob_a;
	localparam logic [8:0] rst_len = 9'(reset_pulse_cyc);
	always_comb begin
		wt_nxt = wt_r;
		cb_nxt = cb_r;
		gate_nxt = gate_r;
		poll_nxt = poll_r;
		rst_cnt_nxt = rst_cnt_r;
		kbd_tx_nxt = 1'b0;
		aux_tx_nxt = 1'b0;
		tx_nxt = tx_data;
		pw_wa_nxt = pw_wa_r;
		pw_ld_nxt = pw_ld_r;
		pw_act_nxt = pw_act_r;
		pw_we = 1'b0;
		ob_d = 8'h00;
		ob_l = 1'b0;
		ob_a = 1'b0;
		consume = 1'b0;
		if (rst_cnt_r != 9'h000) rst_cnt_nxt = rst_cnt_r - 9'h001;
		// answers wait until the host has drained the output buffer
		if (ibf_r && !obf) begin
			consume = 1'b1;
			if (cd_r) begin
				wt_nxt = st_idle; // a new command cancels a pending parameter
				if (ib_r[7:4] == c_reset_grp) begin
					if (!ib_r[0]) rst_cnt_nxt = rst_len; // RULE_22
				end else begin
					unique case (ib_r)
						c_rd_cb: begin ob_d = cb_r; ob_l = 1'b1; end // RULE_11
						c_wr_cb: wt_nxt = st_wr_cb; // RULE_11
						c_pw_test: begin // RULE_12
							ob_d = pw_ld_r ? r_pw_loaded : r_pw_none;
							ob_l = 1'b1;
						end
						c_pw_load: begin // RULE_13
							wt_nxt = st_pw;
							pw_wa_nxt = '0;
							pw_ld_nxt = 1'b0;
						end
						c_pw_en: pw_act_nxt = pw_ld_r; // RULE_14
						c_aux_dis: cb_nxt[cb_adis] = 1'b1; // RULE_24
						c_aux_en: cb_nxt[cb_adis] = 1'b0; // RULE_24
						c_kbd_dis: cb_nxt[cb_kdis] = 1'b1; // RULE_24
						c_kbd_en: cb_nxt[cb_kdis] = 1'b0; // RULE_24
						c_aux_test: begin ob_d = aux_diag; ob_l = 1'b1; end // RULE_15
						c_kbd_test: begin ob_d = kbd_diag; ob_l = 1'b1; end // RULE_15
						c_self_test: begin // RULE_16
							ob_d = self_test_ok ? r_self_ok : 8'h00;
							ob_l = 1'b1;
						end
						c_rd_in: begin ob_d = host_input_port; ob_l = 1'b1; end // RULE_17
						c_poll_lo: poll_nxt = 2'b01; // RULE_17
						c_poll_hi: poll_nxt = 2'b10; // RULE_17
						c_rd_out: begin // RULE_17
							ob_d = {6'h00, gate_r, cpu_reset_line};
							ob_l = 1'b1;
						end
						c_gate: wt_nxt = st_gate; // RULE_18
						c_echo_kbd: wt_nxt = st_echo_k; // RULE_19
						c_echo_aux: wt_nxt = st_echo_a; // RULE_19
						c_wr_aux: wt_nxt = st_aux_wr; // RULE_20
						c_rd_test: begin ob_d = {6'h00, test_inputs}; ob_l = 1'b1; end // RULE_21
						default: ;
					endcase
				end
			end else begin
				unique case (wt_r)
					st_idle: begin kbd_tx_nxt = 1'b1; tx_nxt = ib_r; end // RULE_03
					st_wr_cb: begin cb_nxt = ib_r & cb_mask; wt_nxt = st_idle; end // RULE_11
					st_pw: begin // RULE_13
						if (ib_r == 8'h00) begin
							wt_nxt = st_idle;
							pw_ld_nxt = pw_wa_r != '0;
						end else if (pw_wa_r != aw'(pw_len - 1)) begin
							pw_we = 1'b1;
							pw_wa_nxt = pw_wa_r + 1'b1;
						end
					end
					st_gate: begin gate_nxt = ib_r[gate_bit]; wt_nxt = st_idle; end // RULE_18
					st_echo_k: begin ob_d = ib_r; ob_l = 1'b1; wt_nxt = st_idle; end // RULE_19
					st_echo_a: begin ob_d = ib_r; ob_l = 1'b1; ob_a = 1'b1; wt_nxt = st_idle; end // RULE_19
					st_aux_wr: begin aux_tx_nxt = 1'b1; tx_nxt = ib_r; wt_nxt = st_idle; end // RULE_20
					default: wt_nxt = st_idle;
				endcase
			end
		end else if (rx_valid && !obf) begin
			ob_d = rx_data;
			ob_l = 1'b1;
			ob_a = rx_aux; // RULE_08
		end
	end
	assign ob_ld.load = ob_l;
	assign ob_ld.data = ob_d;
	assign ob_ld.aux = ob_a;

	// ==========================================================
	// keystroke match against the stored password
	always_comb begin
		pw_ra_nxt = pw_ra_r;
		pw_hit_nxt = 1'b0;
		if (!pw_act_r) pw_ra_nxt = '0;
		else if (rx_valid && !rx_aux) begin // RULE_14
			if (rx_data == pw_rd) begin
				if (pw_ra_r + 1'b1 == pw_wa_r) begin
					pw_hit_nxt = 1'b1;
					pw_ra_nxt = '0;
				end else pw_ra_nxt = pw_ra_r + 1'b1;
			end else pw_ra_nxt = '0;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ib_r <= 8'h00;
			ibf_r <= 1'b0;
			cd_r <= 1'b0;
			wt_r <= st_idle;
			cb_r <= cb_reset; // RULE_06
			gate_r <= 1'b0;
			poll_r <= 2'b00;
			rst_cnt_r <= 9'h000;
			kbd_tx_valid <= 1'b0;
			aux_tx_valid <= 1'b0;
			tx_data <= 8'h00;
			pw_wa_r <= '0;
			pw_ra_r <= '0;
			pw_ld_r <= 1'b0;
			pw_act_r <= 1'b0;
			pw_hit_r <= 1'b0;
		end else if (ce) begin
			ib_r <= ib_nxt;
			ibf_r <= ibf_nxt;
			cd_r <= cd_nxt;
			wt_r <= wt_nxt;
			cb_r <= cb_nxt;
			gate_r <= gate_nxt;
			poll_r <= poll_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			kbd_tx_valid <= kbd_tx_nxt;
			aux_tx_valid <= aux_tx_nxt;
			tx_data <= tx_nxt;
			pw_wa_r <= pw_wa_nxt;
			pw_ra_r <= pw_ra_nxt;
			pw_ld_r <= pw_ld_nxt;
			pw_act_r <= pw_act_nxt;
			pw_hit_r <= pw_hit_nxt;
		end
	end

	// ==========================================================
	// status and read data
	logic [7:0] status;
	always_comb begin
		status = 8'h00;
		status[st_obf] = obf; // RULE_05
		status[st_ibf] = ibf_r; // RULE_05
		status[st_sys] = cb_r[cb_sys]; // RULE_06
		status[st_cd] = cd_r; // RULE_02
		status[st_inh] = inhibit_n; // RULE_07
		status[st_aux] = ob_aux; // RULE_08
		status[st_tmo] = timeout_err; // RULE_09
		status[st_par] = parity_err; // RULE_10
		// nibble polling replaces the upper status bits
		if (poll_r == 2'b01) status[7:4] = controller_input_lines[3:0]; // RULE_17
		if (poll_r == 2'b10) status[7:4] = controller_input_lines[7:4]; // RULE_17
	end
	// status read has no side effect on either buffer
	assign io_rdata = (io_addr == cmd_port_addr) ? status : ob_data; // RULE_04
	assign pw_active = pw_act_r;
	assign pw_match = pw_hit_r;
	assign cmd_byte = cb_r;
	assign address_line_20_gate = gate_r; // RULE_18
	assign cpu_reset_line = rst_cnt_r == 9'h000; // RULE_22
endmodule : kbc_host_port

// file: tb/kbc_host_port_monitor.sv
// concurrent checks on the host port pins
module kbc_host_port_monitor
	import kbc_host_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic inhibit_n,
	input wire logic timeout_err,
	input wire logic parity_err,
	input wire logic kbd_tx_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic address_line_20_gate,
	input wire logic cpu_reset_line
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int pulse_len = reset_pulse_cyc;
	logic poll_r;
	int lo_r;
	wire logic at_status = io_addr == cmd_port_addr;
	wire logic idle_wr = io_wr && at_status && !io_rdata[st_ibf] && !io_rdata[st_obf];
	// ========
	// helpers
	// nibble polling takes over the upper status bits until reset
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			poll_r <= 1'b0;
			lo_r <= 0;
		end else begin
			if (io_wr && at_status && (io_wdata == c_poll_lo || io_wdata == c_poll_hi))
				poll_r <= 1'b1;
			lo_r <= cpu_reset_line ? 0 : lo_r + 1;
		end
	end
	// ========
	// checks
	default clocking mclk @(posedge core_clk); endclocking
	default disable iff (!rstn);
	cmd_mark_a: assert property (io_wr && at_status && !io_rdata[st_ibf] ##1 at_status |-> io_rdata[1] && io_rdata[3])
		else $error("command write not flagged in status");
	line_bits_a: assert property (at_status && !poll_r |->
		io_rdata[st_inh] == inhibit_n && io_rdata[st_tmo] == timeout_err && io_rdata[st_par] == parity_err)
		else $error("status line bits differ from inputs");
	sys_mirror_a: assert property (at_status |-> io_rdata[st_sys] == cmd_byte[cb_sys])
		else $error("system flag differs from command byte");
	cb_reserved_a: assert property (cmd_byte[7] == 1'b0 && cmd_byte[3] == 1'b0)
		else $error("reserved command byte bit set");
	cb_cause_a: assert property ($changed(cmd_byte) |-> $past(io_wr, 2))
		else $error("command byte changed without a write");
	status_quiet_a: assert property (at_status && io_rdata[st_obf] && !io_wr ##1 at_status |-> io_rdata[st_obf])
		else $error("status read disturbed output buffer");
	pulse_start_a: assert property (idle_wr && io_wdata == 8'hfe && cpu_reset_line |-> ##[1:2] !cpu_reset_line)
		else $error("even reset command gave no pulse");
	pulse_odd_a: assert property (idle_wr && io_wdata == 8'hff && cpu_reset_line |=> cpu_reset_line [*4])
		else $error("odd reset command pulsed");
	pulse_len_a: assert property ($rose(cpu_reset_line) |-> lo_r == pulse_len)
		else $error("reset pulse length wrong");
	gate_cause_a: assert property ($changed(address_line_20_gate) |->
		$past(io_wr, 2) && $past(io_wdata[gate_bit], 2) == address_line_20_gate)
		else $error("gate changed without matching data");
	kbd_pulse_a: assert property (kbd_tx_valid |=> !kbd_tx_valid)
		else $error("keyboard send pulse too long");
endmodule : kbc_host_port_monitor

bind kbc_host_port kbc_host_port_monitor mon (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
	.io_wdata(io_wdata), .io_rdata(io_rdata), .inhibit_n(inhibit_n), .timeout_err(timeout_err),
	.parity_err(parity_err), .kbd_tx_valid(kbd_tx_valid), .cmd_byte(cmd_byte),
	.address_line_20_gate(address_line_20_gate), .cpu_reset_line(cpu_reset_line));

// file: tb/host_cpu_model.sv
// host processor model issuing port reads and writes
module host_cpu_model
	import kbc_host_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] io_rdata,
	output logic [7:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		io_addr = cmd_port_addr;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// bounded wait; a stuck flag is left to the bench watchdog
	task automatic poll(input int bit_i, input logic want);
		for (int i = 0; i < 400; i++) begin
			@(posedge core_clk);
			io_addr <= cmd_port_addr;
			#1;
			if (io_rdata[bit_i] === want)
				break;
		end
	endtask : poll
	task automatic st(output logic [7:0] v);
		@(posedge core_clk);
		io_addr <= cmd_port_addr;
		#1;
		v = io_rdata;
	endtask : st
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		poll(st_ibf, 1'b0);
		@(posedge core_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge core_clk);
		io_wr <= 1'b0;
	endtask : wr
	task automatic rd(output logic [7:0] v);
		poll(st_obf, 1'b1);
		@(posedge core_clk);
		io_addr <= data_port_addr;
		io_rd <= 1'b1;
		#1;
		v = io_rdata;
		@(posedge core_clk);
		io_rd <= 1'b0;
	endtask : rd
endmodule : host_cpu_model

// file: tb/kbc_host_port_tb_top.sv
// self-checking bench for the keyboard controller host port
module kbc_host_port_tb_top import kbc_host_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] hin = 8'ha6, lines = 8'h5a, adiag = 8'h00, kdiag = 8'h00, v, kseen = 8'h00, aseen = 8'h00;
	logic [1:0] tin = 2'b10;
	logic inh_n = 1'b1, tmo = 1'b0, par = 1'b0, st_ok = 1'b1;
	logic ce = 1'b1, rxv = 1'b0, rxa = 1'b0;
	logic [7:0] rxd = 8'h00;
	wire logic [7:0] io_addr, io_wdata, io_rdata, tx_data, cmd_byte;
	wire logic io_wr, io_rd, kbd_tx, aux_tx, pw_active, pw_match, gate, rst_line;
	int bad_count = 0, n_compared = 0, cyc = 0, n_hit = 0, lo_n, i;
	logic [7:0] dis_c [4] = '{c_aux_en, c_aux_dis, c_kbd_en, c_kbd_dis};
	logic [7:0] dis_e [4] = '{8'h57, 8'h77, 8'h67, 8'h77};
	logic [7:0] tc [5] = '{c_pw_test, c_self_test, c_rd_in, c_rd_test, c_rd_out};
	logic [7:0] te [5] = '{8'hf1, 8'h55, 8'ha6, 8'h02, 8'h03};
	initial forever #10 core_clk = ~core_clk;
	// serial side and clock enable are driven by the tests
	kbc_host_port uut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .host_input_port(hin),
		.controller_input_lines(lines), .test_inputs(tin), .inhibit_n(inh_n), .timeout_err(tmo),
		.parity_err(par), .aux_diag(adiag), .kbd_diag(kdiag), .self_test_ok(st_ok), .rx_valid(rxv),
		.rx_aux(rxa), .rx_data(rxd), .kbd_tx_valid(kbd_tx), .aux_tx_valid(aux_tx), .tx_data(tx_data),
		.pw_active(pw_active), .pw_match(pw_match), .cmd_byte(cmd_byte), .address_line_20_gate(gate),
		.cpu_reset_line(rst_line));
	host_cpu_model host (.core_clk(core_clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata));
	// ========
	// helpers
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic ask(input logic [7:0] c, input logic [7:0] e, input string what);
		host.wr(cmd_port_addr, c);
		host.rd(v);
		chk(what, v, e);
	endtask : ask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// the idle cycle after each byte lets the password store fetch its next byte
	task automatic rx_byte(input logic [7:0] d, input logic a);
		rxd <= d;
		rxa <= a;
		rxv <= 1'b1;
		@(posedge core_clk);
		rxv <= 1'b0;
		@(posedge core_clk);
	endtask : rx_byte
	always @(posedge core_clk) begin
		if (kbd_tx === 1'b1)
			kseen <= tx_data;
		if (aux_tx === 1'b1)
			aseen <= tx_data;
		if (pw_match === 1'b1)
			n_hit++;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	// ========
	// tests
	initial begin
		tick(5);
		rstn <= 1'b1;
		tick(1);
		host.st(v);
		chk("status", v, 8'h10);
		chk("cmd_byte", cmd_byte, 8'h00);
		chk("pins", {6'h0, gate, rst_line}, 8'h01);
		$display("test reset done");
		host.wr(cmd_port_addr, c_wr_cb);
		host.wr(data_port_addr, 8'hff);
		tick(3);
		chk("cmd_byte", cmd_byte, 8'h77);
		host.st(v);
		chk("sys cd", v & 8'h0c, 8'h04);
		ask(c_rd_cb, 8'h77, "rd cb");
		for (i = 0; i < 4; i++) begin
			host.wr(cmd_port_addr, dis_c[i]);
			tick(3);
			chk("dis bits", cmd_byte, dis_e[i]);
		end
		$display("test command byte done");
		for (i = 0; i < 2; i++) begin
			host.wr(cmd_port_addr, c_gate);
			host.wr(data_port_addr, i ? 8'h02 : 8'hfd);
			tick(3);
			chk("gate", {7'h0, gate}, i[7:0]);
		end
		for (i = 0; i < 5; i++) begin
			adiag <= i[7:0];
			kdiag <= 8'h04 - i[7:0];
			ask(c_aux_test, i[7:0], "aux test");
			ask(c_kbd_test, 8'h04 - i[7:0], "kbd test");
		end
		for (i = 0; i < 5; i++)
			ask(tc[i], te[i], "answer");
		st_ok <= 1'b0;
		ask(c_self_test, 8'h00, "self test fail");
		$display("test answers done");
		host.wr(cmd_port_addr, c_pw_load);
		host.wr(data_port_addr, 8'h11);
		host.wr(data_port_addr, 8'h22);
		host.wr(data_port_addr, 8'h00);
		ask(c_pw_test, 8'hfa, "pw test");
		host.wr(cmd_port_addr, c_pw_en);
		tick(3);
		chk("pw on", {7'h0, pw_active}, 8'h01);
		chk("no kbd tx", kseen, 8'h00);
		rx_byte(8'h11, 1'b0);
		rx_byte(8'h22, 1'b0);
		tick(2);
		chk("pw hit", n_hit[7:0], 8'h01);
		host.st(v);
		chk("kbd rx", v & 8'h21, 8'h01);
		host.rd(v);
		chk("rx data", v, 8'h11);
		rx_byte(8'h5b, 1'b1);
		host.st(v);
		chk("aux rx", v & 8'h21, 8'h21);
		host.rd(v);
		chk("aux data", v, 8'h5b);
		$display("test password done");
		for (i = 0; i < 2; i++) begin
			host.wr(cmd_port_addr, c_echo_kbd + i[7:0]);
			host.wr(data_port_addr, 8'h3c + i[7:0]);
			tick(3);
			host.st(v);
			chk("aux flag", v & 8'h21, {2'h0, i[0], 5'h01});
			host.rd(v);
			chk("echo", v, 8'h3c + i[7:0]);
		end
		host.wr(data_port_addr, 8'h9e);
		host.wr(cmd_port_addr, c_wr_aux);
		host.wr(data_port_addr, 8'h47);
		tick(3);
		chk("kbd tx", kseen, 8'h9e);
		chk("aux tx", aseen, 8'h47);
		host.wr(data_port_addr, 8'h6d);
		ce <= 1'b0;
		tick(4);
		chk("frozen", kseen, 8'h9e);
		ce <= 1'b1;
		tick(3);
		chk("kbd tx", kseen, 8'h6d);
		$display("test forwarding done");
		lo_n = 0;
		host.wr(cmd_port_addr, 8'hff);
		host.wr(cmd_port_addr, 8'hfe);
		repeat (330) begin
			@(posedge core_clk);
			if (rst_line === 1'b0)
				lo_n++;
		end
		chk("pulse", {7'h0, lo_n == reset_pulse_cyc}, 8'h01);
		inh_n <= 1'b0;
		tmo <= 1'b1;
		par <= 1'b1;
		tick(2);
		host.st(v);
		chk("line bits", v & 8'hd0, 8'hc0);
		for (i = 0; i < 2; i++) begin
			host.wr(cmd_port_addr, c_poll_lo + i[7:0]);
			tick(3);
			host.st(v);
			chk("poll", v & 8'hf0, i ? 8'h50 : 8'ha0);
		end
		$display("test reset pulse and status done");
		final_report();
	end
endmodule : kbc_host_port_tb_top
